// ==== pkg/rx_filter_pkg.sv ====
// constants, register map and carrier types of the receive frame address filter
package rx_filter_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_PAN    = 8'h04;
    localparam logic [7:0] OFF_SHORT  = 8'h08;
    localparam logic [7:0] OFF_EXT_LO = 8'h0C;
    localparam logic [7:0] OFF_EXT_HI = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    // control register field positions
    localparam int CTRL_AUTO_ACK = 0;
    localparam int CTRL_UPLOAD   = 1;
    localparam int CTRL_FILT     = 2;
    localparam int CTRL_COORD    = 3;
    localparam int CTRL_POLICY   = 4;
    localparam int CTRL_MASK     = 6;
    // status register field positions
    localparam int STAT_SEQ  = 0;
    localparam int STAT_PASS = 8;
    localparam int STAT_DONE = 9;
    localparam int STAT_SEC  = 10;
    localparam int STAT_PLEN = 16;
    // reset values
    localparam logic [6:0]  CTRL_RST  = 7'h00;
    localparam logic [15:0] PAN_RST   = 16'hFFFF;
    localparam logic [15:0] SHORT_RST = 16'hFFFF;
    localparam logic [63:0] EXT_RST   = 64'h0;
    // frame control field layout and codes
    localparam int FCF_SEC  = 3;
    localparam int FCF_AR   = 5;
    localparam int FCF_COMP = 6;
    localparam int FCF_DM   = 10;
    localparam int FCF_VER  = 12;
    localparam int FCF_SM   = 14;
    localparam logic [15:0] BCAST     = 16'hFFFF;
    localparam logic [2:0]  FT_BEACON = 3'h0;
    localparam logic [2:0]  FT_DATA   = 3'h1;
    localparam logic [2:0]  FT_ACK    = 3'h2;
    localparam logic [2:0]  FT_CMD    = 3'h3;
    localparam logic [1:0]  AM_NONE   = 2'h0;
    localparam logic [1:0]  AM_SHORT  = 2'h2;
    localparam logic [1:0]  AM_EXT    = 2'h3;
    localparam logic [1:0]  POL_ALL   = 2'h3;
    localparam logic [7:0]  FCS_LEN   = 8'h02;
    localparam logic [2:0]  LAST_W16  = 3'h1;
    localparam logic [2:0]  LAST_W64  = 3'h7;

    typedef struct packed {
        logic        auto_ack;
        logic        upload;
        logic        filt;
        logic        coord;
        logic [1:0]  policy;
        logic        irq_mask;
        logic [15:0] pan;
        logic [15:0] short_addr;
        logic [63:0] ext_addr;
    } cfg_t;

    typedef struct packed {
        logic [7:0] plen;
        logic       sec;
        logic       done;
        logic       pass;
        logic [7:0] seq;
    } status_t;

    typedef enum logic [3:0] {
        ST_IDLE, ST_FCF0, ST_FCF1, ST_SEQ, ST_DPAN, ST_DADR, ST_SPAN, ST_SADR, ST_BODY
    } pstate_t;
endpackage : rx_filter_pkg

// ==== rtl/filter_regs.sv ====
// classic wishbone register slave holding filter configuration and status
`timescale 1ns/1ps
module filter_regs import rx_filter_pkg::*; (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // block side
    input  wire status_t     status_i,
    output cfg_t             cfg_o
);
    logic [6:0]  ctrl_q, ctrl_d;
    logic [15:0] pan_q, pan_d, sh_q, sh_d;
    logic [63:0] ext_q, ext_d;
    logic [31:0] dat_q, dat_d;
    logic        ack_q, ack_d;
    logic        req;

    // merge write data into an old word under byte enables
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] sel);
        merge = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                merge[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
    endfunction : merge

    assign req = wb_cyc_i & wb_stb_i & ~ack_q;

    // decode; unmapped reads return zero and writes are dropped, still acked
    always_comb begin
        ctrl_d = ctrl_q;
        pan_d  = pan_q;
        sh_d   = sh_q;
        ext_d  = ext_q;
        dat_d  = dat_q;
        ack_d  = req;
        if (req) begin
            case (wb_adr_i)
                OFF_CTRL:   dat_d = {25'h0, ctrl_q};
                OFF_PAN:    dat_d = {16'h0, pan_q};
                OFF_SHORT:  dat_d = {16'h0, sh_q};
                OFF_EXT_LO: dat_d = ext_q[31:0];
                OFF_EXT_HI: dat_d = ext_q[63:32];
                OFF_STATUS: dat_d = {8'h00, status_i.plen, 5'h0, status_i.sec, status_i.done,
                                     status_i.pass, status_i.seq};
                default:    dat_d = 32'h0;
            endcase
            if (wb_we_i) begin
                case (wb_adr_i)
                    OFF_CTRL:   ctrl_d = 7'(merge({25'h0, ctrl_q}, wb_dat_i, wb_sel_i));
                    OFF_PAN:    pan_d = 16'(merge({16'h0, pan_q}, wb_dat_i, wb_sel_i));
                    OFF_SHORT:  sh_d = 16'(merge({16'h0, sh_q}, wb_dat_i, wb_sel_i));
                    OFF_EXT_LO: ext_d[31:0] = merge(ext_q[31:0], wb_dat_i, wb_sel_i);
                    OFF_EXT_HI: ext_d[63:32] = merge(ext_q[63:32], wb_dat_i, wb_sel_i);
                    default:    ;
                endcase
            end
        end
    end

    // register stage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= CTRL_RST;
            pan_q  <= PAN_RST;
            sh_q   <= SHORT_RST;
            ext_q  <= EXT_RST;
            dat_q  <= 32'h0;
            ack_q  <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            pan_q  <= pan_d;
            sh_q   <= sh_d;
            ext_q  <= ext_d;
            dat_q  <= dat_d;
            ack_q  <= ack_d;
        end
    end

    assign wb_dat_o = dat_q;
    assign wb_ack_o = ack_q;
    assign cfg_o    = '{auto_ack: ctrl_q[CTRL_AUTO_ACK], upload: ctrl_q[CTRL_UPLOAD],
                        filt: ctrl_q[CTRL_FILT], coord: ctrl_q[CTRL_COORD],
                        policy: ctrl_q[CTRL_POLICY +: 2], irq_mask: ctrl_q[CTRL_MASK],
                        pan: pan_q, short_addr: sh_q, ext_addr: ext_q};
endmodule : filter_regs

// ==== rtl/filter_decide.sv ====
// combinational third-level filter decision over latched header fields
`timescale 1ns/1ps
module filter_decide import rx_filter_pkg::*; (
    // header fields and configuration
    input  wire logic [15:0] fcf_i,
    input  wire logic [15:0] dpan_i,
    input  wire logic [63:0] dadr_i,
    input  wire logic [15:0] span_i,
    input  wire cfg_t        cfg_i,
    // verdict
    output logic             pass_o,
    output logic             irq_ok_o,
    output logic             bypass_o
);
    logic [2:0] ft;
    logic [1:0] dm, sm, ver;
    logic       hd, hs, rsv, ver_ok, dpan_ok, dadr_ok, bcn_ok, src_ok, filt_ok;

    // decode fcf; addressing mode 1 is treated as no field
    always_comb begin
        ft  = fcf_i[2:0];
        dm  = fcf_i[FCF_DM +: 2];
        sm  = fcf_i[FCF_SM +: 2];
        ver = fcf_i[FCF_VER +: 2];
        hd  = dm[1];
        hs  = sm[1];
        rsv = ft > FT_CMD;
        ver_ok  = (cfg_i.policy == POL_ALL) || (ver <= cfg_i.policy);
        dpan_ok = !hd || dpan_i == cfg_i.pan || dpan_i == BCAST;
        dadr_ok = (dm == AM_SHORT) ? (dadr_i[15:0] == cfg_i.short_addr || dadr_i[15:0] == BCAST)
                : (dm == AM_EXT) ? (dadr_i == cfg_i.ext_addr) : 1'b1;
        bcn_ok  = ft != FT_BEACON || cfg_i.pan == BCAST || span_i == cfg_i.pan;
        // reserved types filtered like data frames when enabled
        src_ok  = hd || !(ft == FT_DATA || ft == FT_CMD || rsv)
                || (cfg_i.coord && span_i == cfg_i.pan);
        filt_ok = ver_ok && dpan_ok && dadr_ok && bcn_ok && src_ok
                && ft != FT_ACK && (hd || hs);
        bypass_o = rsv && cfg_i.upload && !cfg_i.filt;
        if (rsv && !cfg_i.upload) begin
            pass_o = 1'b0;
        end else if (bypass_o) begin
            pass_o = 1'b1;
        end else begin
            pass_o = filt_ok;
        end
        irq_ok_o = !bypass_o && !(dm <= 2'h1 && sm == AM_NONE);
    end
endmodule : filter_decide

// ==== rtl/rx_frame_address_filter.sv ====
// receive frame header parser with address filter, match interrupt and ack sequence
//
// The Wishbone slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module rx_frame_address_filter import rx_filter_pkg::*; (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // receive octet stream
    input  wire logic        rx_start_i,
    input  wire logic        rx_valid_i,
    input  wire logic [7:0]  rx_data_i,
    input  wire logic        rx_end_i,
    // verdict and acknowledgement
    output logic             frame_pass_o,
    output logic             address_match_irq_o,
    output logic             ack_gen_o,
    output logic      [7:0]  ack_seq_o
);
    cfg_t        cfg;
    status_t     stat_q, stat_d;
    pstate_t     st_q, st_d;
    logic [2:0]  fc_q, fc_d;
    logic [7:0]  cnt_q, cnt_d, hlen_q, hlen_d, seq_q, seq_d;
    logic [63:0] sh_q, sh_d, dadr_q, dadr_d;
    logic [15:0] fcf_q, fcf_d, dpan_q, dpan_d, span_q, span_d, span_eff;
    logic        hdone_q, hdone_d;
    logic        pass_q, pass_d, irq_q, irq_d, ackg_q, ackg_d;
    logic [7:0]  aseq_q, aseq_d;
    logic        pass_w, irq_ok_w, bypass_w;

    // field that follows the current one
    function automatic pstate_t next_field(input pstate_t cur, input logic [15:0] fcf);
        logic hd;
        logic hs;
        logic sp;
        hd = fcf[FCF_DM + 1];
        hs = fcf[FCF_SM + 1];
        sp = hs && !(fcf[FCF_COMP] && hd);
        case (cur)
            ST_SEQ:  next_field = hd ? ST_DPAN : sp ? ST_SPAN : hs ? ST_SADR : ST_BODY;
            ST_DPAN: next_field = ST_DADR;
            ST_DADR: next_field = sp ? ST_SPAN : hs ? ST_SADR : ST_BODY;
            ST_SPAN: next_field = ST_SADR;
            default: next_field = ST_BODY;
        endcase
    endfunction : next_field

    // index of the last octet of an address field
    function automatic logic [2:0] field_last(input pstate_t cur, input logic [15:0] fcf);
        case (cur)
            ST_DADR: field_last = (fcf[FCF_DM +: 2] == AM_EXT) ? LAST_W64 : LAST_W16;
            ST_SADR: field_last = (fcf[FCF_SM +: 2] == AM_EXT) ? LAST_W64 : LAST_W16;
            default: field_last = LAST_W16;
        endcase
    endfunction : field_last

    filter_regs u_regs (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .wb_cyc_i (wb_cyc_i),
        .wb_stb_i (wb_stb_i),
        .wb_we_i  (wb_we_i),
        .wb_adr_i (wb_adr_i),
        .wb_sel_i (wb_sel_i),
        .wb_dat_i (wb_dat_i),
        .wb_dat_o (wb_dat_o),
        .wb_ack_o (wb_ack_o),
        .status_i (stat_q),
        .cfg_o    (cfg)
    );

    // compressed source pan inherits the destination pan
    assign span_eff = (fcf_q[FCF_COMP] && fcf_q[FCF_DM + 1]) ? dpan_q : span_q;

    filter_decide u_decide (
        .fcf_i    (fcf_q),
        .dpan_i   (dpan_q),
        .dadr_i   (dadr_q),
        .span_i   (span_eff),
        .cfg_i    (cfg),
        .pass_o   (pass_w),
        .irq_ok_o (irq_ok_w),
        .bypass_o (bypass_w)
    );

    // header parser; octets shift in from the top, so fields read little-endian
    always_comb begin
        st_d    = st_q;
        fc_d    = fc_q;
        cnt_d   = cnt_q;
        hlen_d  = hlen_q;
        seq_d   = seq_q;
        sh_d    = sh_q;
        fcf_d   = fcf_q;
        dpan_d  = dpan_q;
        dadr_d  = dadr_q;
        span_d  = span_q;
        hdone_d = 1'b0;
        if (rx_start_i) begin
            st_d  = ST_FCF0;
            fc_d  = 3'h0;
            cnt_d = 8'h00;
        end else if (rx_end_i) begin
            st_d = ST_IDLE;                          // a truncated header never gets a verdict
        end else if (rx_valid_i && st_q != ST_IDLE) begin
            cnt_d = cnt_q + 8'h01;
            sh_d  = {rx_data_i, sh_q[63:8]};
            case (st_q)
                ST_FCF0: st_d = ST_FCF1;
                ST_FCF1: begin
                    fcf_d = sh_d[63:48];
                    st_d  = ST_SEQ;
                end
                ST_SEQ: begin
                    seq_d = rx_data_i;
                    st_d  = next_field(ST_SEQ, fcf_q);
                end
                ST_DPAN, ST_DADR, ST_SPAN, ST_SADR: begin
                    if (fc_q == field_last(st_q, fcf_q)) begin
                        fc_d = 3'h0;
                        st_d = next_field(st_q, fcf_q);
                        case (st_q)
                            ST_DPAN: dpan_d = sh_d[63:48];
                            ST_DADR: dadr_d = (fcf_q[FCF_DM +: 2] == AM_EXT) ? sh_d : {48'h0, sh_d[63:48]};
                            ST_SPAN: span_d = sh_d[63:48];
                            default: ;       // source address is not needed for the verdict
                        endcase
                    end else begin
                        fc_d = fc_q + 3'h1;
                    end
                end
                default: ;                   // body octets, incl. any security header, only counted
            endcase
            if (st_d == ST_BODY && st_q != ST_BODY) begin
                hdone_d = 1'b1;
                hlen_d  = cnt_d;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q    <= ST_IDLE;
            fc_q    <= 3'h0;
            cnt_q   <= 8'h00;
            hlen_q  <= 8'h00;
            seq_q   <= 8'h00;
            sh_q    <= 64'h0;
            fcf_q   <= 16'h0;
            dpan_q  <= 16'h0;
            dadr_q  <= 64'h0;
            span_q  <= 16'h0;
            hdone_q <= 1'b0;
        end else begin
            st_q    <= st_d;
            fc_q    <= fc_d;
            cnt_q   <= cnt_d;
            hlen_q  <= hlen_d;
            seq_q   <= seq_d;
            sh_q    <= sh_d;
            fcf_q   <= fcf_d;
            dpan_q  <= dpan_d;
            dadr_q  <= dadr_d;
            span_q  <= span_d;
            hdone_q <= hdone_d;
        end
    end

    // verdict pulses two cycles after the last header octet, plus status
    always_comb begin
        pass_d = 1'b0;
        irq_d  = 1'b0;
        ackg_d = 1'b0;
        aseq_d = aseq_q;
        stat_d = stat_q;
        if (rx_start_i) begin
            stat_d = '0;
        end else begin
            if (hdone_q) begin
                pass_d = pass_w;
                irq_d  = pass_w && irq_ok_w && !cfg.irq_mask;
                // bypassed reserved frames ignore the ack request
                ackg_d = pass_w && cfg.auto_ack && fcf_q[FCF_AR] && !bypass_w;
                aseq_d = seq_q;
                stat_d.pass = pass_w;
                stat_d.seq  = seq_q;
                stat_d.sec  = fcf_q[FCF_SEC];
            end
            if (rx_end_i && st_q != ST_IDLE) begin
                stat_d.done = 1'b1;
                // payload excludes header and trailing checksum
                stat_d.plen = (st_q == ST_BODY && cnt_q >= hlen_q + FCS_LEN)
                            ? cnt_q - hlen_q - FCS_LEN : 8'h00;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pass_q <= 1'b0;
            irq_q  <= 1'b0;
            ackg_q <= 1'b0;
            aseq_q <= 8'h00;
            stat_q <= '0;
        end else begin
            pass_q <= pass_d;
            irq_q  <= irq_d;
            ackg_q <= ackg_d;
            aseq_q <= aseq_d;
            stat_q <= stat_d;
        end
    end

    assign frame_pass_o        = pass_q;
    assign address_match_irq_o = irq_q;
    assign ack_gen_o           = ackg_q;
    assign ack_seq_o           = aseq_q;

    // checks on the verdict path
    logic filt_on;
    assign filt_on = fcf_q[2:0] <= FT_CMD || cfg.filt;

    property p_ack_seq;
        @(posedge clk_i) disable iff (rst_i) ack_gen_o |-> ack_seq_o == seq_q && frame_pass_o;
    endproperty
    a_ack_seq: assert property (p_ack_seq) else $error("ack sequence mismatch");

    property p_irq_pass;
        @(posedge clk_i) disable iff (rst_i) address_match_irq_o |-> frame_pass_o && !cfg.irq_mask;
    endproperty
    a_irq_pass: assert property (p_irq_pass) else $error("irq without pass");

    property p_no_ack_frame;
        @(posedge clk_i) disable iff (rst_i) frame_pass_o |-> fcf_q[2:0] != FT_ACK;
    endproperty
    a_no_ack_frame: assert property (p_no_ack_frame) else $error("ack frame passed");

    property p_addr_present;
        @(posedge clk_i) disable iff (rst_i)
            frame_pass_o && filt_on |-> fcf_q[FCF_DM + 1] || fcf_q[FCF_SM + 1];
    endproperty
    a_addr_present: assert property (p_addr_present) else $error("no address passed");

    property p_irq_mode;
        @(posedge clk_i) disable iff (rst_i)
            address_match_irq_o |-> !(fcf_q[FCF_DM + 1] == 1'b0 && fcf_q[FCF_SM +: 2] == AM_NONE);
    endproperty
    a_irq_mode: assert property (p_irq_mode) else $error("irq on no-address frame");

    property p_dpan;
        @(posedge clk_i) disable iff (rst_i)
            frame_pass_o && filt_on && fcf_q[FCF_DM + 1] |-> dpan_q == cfg.pan || dpan_q == BCAST;
    endproperty
    a_dpan: assert property (p_dpan) else $error("destination pan mismatch passed");

    property p_version;
        @(posedge clk_i) disable iff (rst_i)
            frame_pass_o && filt_on && cfg.policy != POL_ALL |-> fcf_q[FCF_VER +: 2] <= cfg.policy;
    endproperty
    a_version: assert property (p_version) else $error("version beyond policy passed");

    property p_rsv;
        @(posedge clk_i) disable iff (rst_i) frame_pass_o && fcf_q[2:0] > FT_CMD |-> cfg.upload;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved type passed without upload");

    property p_beacon;
        @(posedge clk_i) disable iff (rst_i)
            frame_pass_o && fcf_q[2:0] == FT_BEACON && cfg.pan != BCAST |-> span_eff == cfg.pan;
    endproperty
    a_beacon: assert property (p_beacon) else $error("beacon pan mismatch passed");

    property p_timing;
        @(posedge clk_i) disable iff (rst_i) hdone_q && !rx_start_i |=> frame_pass_o == $past(pass_w);
    endproperty
    a_timing: assert property (p_timing) else $error("verdict not one cycle after header");

    c_match: cover property (@(posedge clk_i) disable iff (rst_i) address_match_irq_o);
    c_reject: cover property (@(posedge clk_i) disable iff (rst_i) hdone_q && !pass_w);
    c_ack: cover property (@(posedge clk_i) disable iff (rst_i) ack_gen_o);
endmodule : rx_frame_address_filter

// ==== sim/rx_source.sv ====
// radio receive path model feeding frame octets to the filter
`timescale 1ns/1ps
module rx_source (
    // clock
    input  wire logic       clk_i,
    // octet stream
    output logic            rx_start_o = 1'b0,
    output logic            rx_valid_o = 1'b0,
    output logic      [7:0] rx_data_o  = 8'h00,
    output logic            rx_end_o   = 1'b0
);
    // start pulse, octets in order, end pulse after the two checksum octets
    task automatic send(input logic [7:0] q[$], input int gap);
        rx_start_o <= 1'b1;
        @(posedge clk_i);
        rx_start_o <= 1'b0;
        foreach (q[i]) begin
            rx_valid_o <= 1'b1;
            rx_data_o  <= q[i];
            @(posedge clk_i);
            if (gap > 0) begin
                rx_valid_o <= 1'b0;
                rx_data_o  <= ~q[i]; // idle line never holds the octet just sent during the gap
                repeat (gap) @(posedge clk_i);
            end
        end
        rx_valid_o <= 1'b0;
        rx_data_o  <= ~rx_data_o;
        rx_end_o   <= 1'b1;
        @(posedge clk_i);
        rx_end_o <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask : send
endmodule : rx_source

// ==== sim/tb_top.sv ====
// self-checking bench: register access and frame filter verdicts
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin fails++; \
    $display("mismatch %s expected %0h seen %0h", n, e, s); end end
module tb_top import rx_filter_pkg::*;;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h00, seq_n = 8'h00, ack_seq;
    logic [31:0] dat = 32'h0, dat_o, r;
    logic        ack, st, vl, en, pass, irq, agen;
    logic [7:0]  rd;
    int          fails = 0, n_compared = 0, n_pass, n_irq, n_ack;
    always #10 clk_i = ~clk_i;
    rx_source src (.clk_i(clk_i), .rx_start_o(st), .rx_valid_o(vl), .rx_data_o(rd), .rx_end_o(en));
    rx_frame_address_filter uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .rx_start_i(st), .rx_valid_i(vl), .rx_data_i(rd), .rx_end_i(en),
        .frame_pass_o(pass), .address_match_irq_o(irq), .ack_gen_o(agen), .ack_seq_o(ack_seq));
    // count verdict pulses per frame
    always @(posedge clk_i) begin
        if (pass === 1'b1) n_pass++;
        if (irq === 1'b1) n_irq++;
        if (agen === 1'b1) n_ack++;
    end
    // classic cycle: hold until ack is sampled, then release for a cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int t;
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        t = 0;
        do begin @(posedge clk_i); t++; end while (ack !== 1'b1 && t < 50);
        `CHK("wb_ack", 1'b1, ack)
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    // one frame; exp holds pass, irq, ack request
    task automatic run(input logic [31:0] c, input logic [15:0] f, p, a, input logic [2:0] exp);
        logic [7:0] q[$];
        wb(1'b1, OFF_CTRL, c, r);
        seq_n = seq_n + 8'h01;
        q = '{f[7:0], f[15:8], seq_n};
        if (f[11:10] >= AM_SHORT) q = {q, p[7:0], p[15:8], a[7:0], a[15:8]};
        if (f[11:10] == AM_EXT) q = {q, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        if (f[15:14] == AM_SHORT && !(f[FCF_COMP] && f[11])) q = {q, p[7:0], p[15:8]};
        if (f[15:14] == AM_SHORT) q = {q, a[7:0], a[15:8]};
        q = {q, 8'h5A, 8'hC3, 8'h3C}; // one payload octet, then checksum
        n_pass = 0;
        n_irq = 0;
        n_ack = 0;
        src.send(q, seq_n[0] ? 2 : 0);
        `CHK("pass", exp[2], n_pass == 1)
        `CHK("irq", exp[1], n_irq == 1)
        `CHK("ack", exp[0], n_ack == 1)
        if (exp[0]) `CHK("ack_seq", seq_n, ack_seq)
        wb(1'b0, OFF_STATUS, 32'h0, r);
        `CHK("done", 1'b1, r[STAT_DONE])
        `CHK("st_pass", exp[2], r[STAT_PASS])
        `CHK("st_seq", seq_n, r[STAT_SEQ+:8])
        if (exp[2]) `CHK("sec", f[FCF_SEC], r[STAT_SEC])
        if (exp[2]) `CHK("plen", 8'h01, r[STAT_PLEN+:8])
    endtask : run
    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : summarize
    // watchdog far beyond the fewer than one thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge clk_i);
        fails++;
        summarize();
    end
    // main sequence
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, OFF_PAN, 32'h0, r);
        `CHK("pan_rst", 32'h0000FFFF, r)
        wb(1'b0, 8'h20, 32'h0, r);
        `CHK("unmapped", 32'h0, r)
        wb(1'b1, OFF_PAN, 32'h1234, r);
        wb(1'b1, OFF_SHORT, 32'h5678, r);
        wb(1'b1, OFF_EXT_LO, 32'h5678, r);
        wb(1'b0, OFF_EXT_LO, 32'h0, r);
        `CHK("ext_lo", 32'h5678, r)
        wb(1'b0, OFF_PAN, 32'h0, r);
        `CHK("pan", 32'h1234, r)
        run(32'h01, 16'h0821, 16'h1234, 16'h5678, 3'h7);
        run(32'h01, 16'h0801, 16'hFFFF, 16'hFFFF, 3'h6);
        run(32'h01, 16'h0821, 16'h1111, 16'h5678, 3'h0);
        run(32'h01, 16'h0821, 16'h1234, 16'h9999, 3'h0);
        run(32'h01, 16'h0822, 16'h1234, 16'h5678, 3'h0);
        run(32'h01, 16'h0824, 16'h1234, 16'h5678, 3'h0);
        run(32'h03, 16'h0824, 16'h1234, 16'h5678, 3'h4);
        run(32'h07, 16'h0824, 16'h1234, 16'h5678, 3'h7);
        run(32'h01, 16'h2821, 16'h1234, 16'h5678, 3'h0);
        run(32'h21, 16'h2821, 16'h1234, 16'h5678, 3'h7);
        run(32'h31, 16'h3821, 16'h1234, 16'h5678, 3'h7);
        run(32'h01, 16'h0829, 16'h1234, 16'h5678, 3'h7);
        run(32'h01, 16'h0001, 16'h1234, 16'h5678, 3'h0);
        run(32'h01, 16'h8001, 16'h1234, 16'h5678, 3'h0);
        run(32'h09, 16'h8001, 16'h1234, 16'h5678, 3'h6);
        run(32'h01, 16'h8000, 16'h1234, 16'h5678, 3'h6);
        run(32'h01, 16'h8000, 16'h4321, 16'h5678, 3'h0);
        run(32'h41, 16'h0821, 16'h1234, 16'h5678, 3'h5);
        run(32'h00, 16'h0821, 16'h1234, 16'h5678, 3'h6);
        run(32'h11, 16'h1821, 16'h1234, 16'h5678, 3'h7);
        run(32'h11, 16'h2821, 16'h1234, 16'h5678, 3'h0);
        run(32'h01, 16'h8C61, 16'h1234, 16'h5678, 3'h7);
        run(32'h01, 16'h8C61, 16'h1234, 16'h5679, 3'h0);
        summarize();
    end
endmodule : tb_top
